// ==== hdl/tfrb_top.sv ====
// Record builder: stamps each transmitted and received frame and emits a 24-byte record header.
// Assumes start/end events and lengths come from MAC logic on clk, and net_time_ns counts whole nanoseconds.
//
// What this block does
// - Record bytes 0-1 carry unsigned total length, including the length bytes.
// - Timestamp taken at start of first symbol after the start-of-frame delimiter.
// - Direct mode references timestamps to the port's connector/PHY plane.
// - Tap mode references timestamps to midpoint between own and partner planes.
// - Bytes 12-19 hold the 64-bit network timestamp from the sync protocol clock.
// - Network timestamp counts whole nanoseconds; zero is the protocol epoch.
// - Bytes 20-23 hold the 32-bit flags word, bit 0 least significant.
// - Flag bit 31 set for transmitted frames, clear otherwise.
// - Direct mode echoes every transmitted endpoint frame onto the monitor view.
// - Tap mode marks frames sent out here after partner reception as transmit.
// - Endpoint view records always carry the transmit flag clear.
// - Flag bit 30 set for received frames, clear otherwise.
`timescale 1ns/1ps
module tfrb_top
	import tfrb_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic tap_mode,
	input wire logic [63:0] net_time_ns,
	input wire logic tx_sof,
	input wire logic tx_eof,
	input wire logic [15:0] tx_len,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [15:0] rx_len,
	output logic [31:0] mon_data,
	output logic mon_last,
	output logic mon_valid,
	input wire logic mon_ready,
	output logic [31:0] ep_data,
	output logic ep_last,
	output logic ep_valid,
	input wire logic ep_ready,
	output logic rec_drop
);

	logic [63:0] tx_adj_ns;
	logic [63:0] rx_adj_ns;
	logic [63:0] tx_sof_ts_q;
	logic [63:0] rx_sof_ts_q;
	logic [63:0] tx_pend_ts_q;
	logic [63:0] rx_pend_ts_q;
	logic [15:0] tx_pend_len_q;
	logic [15:0] rx_pend_len_q;
	logic tx_pend_q;
	logic rx_pend_q;
	tfrb_state_type state_q;
	logic [2:0] idx_q;
	logic [63:0] cur_ts_q;
	logic [15:0] cur_len_q;
	logic cur_tx_q;
	logic take_rx;
	logic take_tx;
	logic mon_in_ready;
	logic ep_in_ready;
	logic wr_fire;
	logic last_word;
	logic [31:0] flags_word;
	logic [31:0] word;
	logic [31:0] ep_word;
	logic [32:0] mon_out;
	logic [32:0] ep_out;
	logic rec_drop_q;

	// Timestamps are moved to the reference plane the port mode asks for.
	tfrb_tsadj u_tx_adj (
		.raw_ns(net_time_ns),
		.is_tx(1'b1),
		.tap_mode(tap_mode),
		.ts_ns(tx_adj_ns)
	);

	tfrb_tsadj u_rx_adj (
		.raw_ns(net_time_ns),
		.is_tx(1'b0),
		.tap_mode(tap_mode),
		.ts_ns(rx_adj_ns)
	);

	// Capture at the first symbol after the delimiter, one slot per direction.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_sof_ts_q <= 64'h0000_0000_0000_0000;
			rx_sof_ts_q <= 64'h0000_0000_0000_0000;
		end else begin
			if (tx_sof) begin
				tx_sof_ts_q <= tx_adj_ns;
			end
			if (rx_sof) begin
				rx_sof_ts_q <= rx_adj_ns;
			end
		end
	end

	// The builder takes a waiting received record before a waiting transmitted one.
	assign take_rx = (state_q == TFRB_ST_IDLE) && rx_pend_q;
	assign take_tx = (state_q == TFRB_ST_IDLE) && !rx_pend_q && tx_pend_q;

	// A finished frame waits here so the next frame's capture cannot overwrite its stamp.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_pend_q <= 1'b0;
			tx_pend_ts_q <= 64'h0000_0000_0000_0000;
			tx_pend_len_q <= 16'h0000;
		end else if (tx_eof && (!tx_pend_q || take_tx)) begin
			// A new frame end in the cycle the slot is taken refills it.
			tx_pend_q <= 1'b1;
			tx_pend_ts_q <= tx_sof_ts_q;
			tx_pend_len_q <= tx_len;
		end else if (take_tx) begin
			tx_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_pend_q <= 1'b0;
			rx_pend_ts_q <= 64'h0000_0000_0000_0000;
			rx_pend_len_q <= 16'h0000;
		end else if (rx_eof && (!rx_pend_q || take_rx)) begin
			rx_pend_q <= 1'b1;
			rx_pend_ts_q <= rx_sof_ts_q;
			rx_pend_len_q <= rx_len;
		end else if (take_rx) begin
			rx_pend_q <= 1'b0;
		end
	end

	// A frame end that finds its slot still occupied is lost and reported.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rec_drop_q <= 1'b0;
		end else begin
			rec_drop_q <= (tx_eof && tx_pend_q && !take_tx) || (rx_eof && rx_pend_q && !take_rx);
		end
	end

	// Words go out only when every view that wants the record can accept them.
	assign wr_fire = (state_q == TFRB_ST_EMIT) && mon_in_ready && (cur_tx_q || ep_in_ready);
	assign last_word = (idx_q == TFRB_W_FLAGS);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= TFRB_ST_IDLE;
			idx_q <= TFRB_W_LEN;
			cur_ts_q <= 64'h0000_0000_0000_0000;
			cur_len_q <= 16'h0000;
			cur_tx_q <= 1'b0;
		end else begin
			case (state_q)
				TFRB_ST_IDLE: begin
					idx_q <= TFRB_W_LEN;
					if (take_rx) begin
						cur_ts_q <= rx_pend_ts_q;
						cur_len_q <= rx_pend_len_q;
						cur_tx_q <= 1'b0;
						state_q <= TFRB_ST_EMIT;
					end else if (take_tx) begin
						cur_ts_q <= tx_pend_ts_q;
						cur_len_q <= tx_pend_len_q;
						cur_tx_q <= 1'b1;
						state_q <= TFRB_ST_EMIT;
					end
				end
				TFRB_ST_EMIT: begin
					if (wr_fire) begin
						if (last_word) begin
							state_q <= TFRB_ST_IDLE;
						end else begin
							idx_q <= 3'(idx_q + 1'b1);
						end
					end
				end
				default: begin
					state_q <= TFRB_ST_IDLE;
				end
			endcase
		end
	end

	// Only the direction bits may be set; bit 0 is the least significant.
	always_comb begin
		flags_word = 32'h0000_0000;
		flags_word[TFRB_FLAG_TX_BIT] = cur_tx_q;
		flags_word[TFRB_FLAG_RX_BIT] = !cur_tx_q;
	end

	// Header words in host byte order; the type and local timestamp are not produced here.
	always_comb begin
		case (idx_q)
			TFRB_W_LEN: word = {16'h0000, 16'(cur_len_q + TFRB_REC_OVERHEAD)};
			TFRB_W_LTS_LO: word = 32'h0000_0000;
			TFRB_W_LTS_HI: word = 32'h0000_0000;
			TFRB_W_NTS_LO: word = cur_ts_q[31:0];
			TFRB_W_NTS_HI: word = cur_ts_q[63:32];
			TFRB_W_FLAGS: word = flags_word;
			default: word = 32'h0000_0000;
		endcase
	end

	// The endpoint view never shows a transmit flag.
	always_comb begin
		ep_word = word;
		if (last_word) begin
			ep_word[TFRB_FLAG_TX_BIT] = 1'b0;
		end
	end

	// Every record goes to the monitor view, so transmits are echoed there in direct mode.
	tfrb_fifo #(
		.WIDTH(TFRB_FIFO_WIDTH),
		.DEPTH(TFRB_FIFO_DEPTH)
	) u_mon_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_data({last_word, word}),
		.in_valid(wr_fire),
		.in_ready(mon_in_ready),
		.out_data(mon_out),
		.out_valid(mon_valid),
		.out_ready(mon_ready)
	);

	// Received records also go to the endpoint view.
	tfrb_fifo #(
		.WIDTH(TFRB_FIFO_WIDTH),
		.DEPTH(TFRB_FIFO_DEPTH)
	) u_ep_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_data({last_word, ep_word}),
		.in_valid(wr_fire && !cur_tx_q),
		.in_ready(ep_in_ready),
		.out_data(ep_out),
		.out_valid(ep_valid),
		.out_ready(ep_ready)
	);

	assign mon_data = mon_out[31:0];
	assign mon_last = mon_out[32];
	assign ep_data = ep_out[31:0];
	assign ep_last = ep_out[32];
	assign rec_drop = rec_drop_q;

	property p_len_word;
		@(posedge clk) disable iff (!rstn)
			(wr_fire && idx_q == TFRB_W_LEN) |-> (word[15:0] == 16'(cur_len_q + 16'h001C));
	endproperty
	a_len_word: assert property (p_len_word) else $error("record length is not frame bytes plus 28");

	property p_tx_capture;
		@(posedge clk) disable iff (!rstn)
			(tx_sof && !tap_mode) |=> (tx_sof_ts_q == $past(net_time_ns) + TFRB_TX_LAT_NS);
	endproperty
	a_tx_capture: assert property (p_tx_capture) else $error("transmit stamp not taken at start of frame");

	property p_rx_direct;
		@(posedge clk) disable iff (!rstn)
			(rx_sof && !tap_mode) |=> (rx_sof_ts_q == $past(net_time_ns) - TFRB_RX_LAT_NS);
	endproperty
	a_rx_direct: assert property (p_rx_direct) else $error("direct receive stamp not at port plane");

	property p_rx_tap;
		@(posedge clk) disable iff (!rstn)
			(rx_sof && tap_mode) |=>
			(rx_sof_ts_q == $past(net_time_ns) - TFRB_RX_LAT_NS + (TFRB_PARTNER_PLANE_NS >> 1));
	endproperty
	a_rx_tap: assert property (p_rx_tap) else $error("tap receive stamp not at midpoint");

	property p_stamp_words;
		@(posedge clk) disable iff (!rstn)
			(wr_fire && (idx_q == TFRB_W_NTS_LO || idx_q == TFRB_W_NTS_HI)) |->
			(word == ((idx_q == TFRB_W_NTS_LO) ? cur_ts_q[31:0] : cur_ts_q[63:32]));
	endproperty
	a_stamp_words: assert property (p_stamp_words) else $error("network stamp words do not match the captured stamp");

	property p_flags_clear;
		@(posedge clk) disable iff (!rstn)
			(wr_fire && last_word) |-> (word[29:0] == 30'h0000_0000);
	endproperty
	a_flags_clear: assert property (p_flags_clear) else $error("unused flag bits are not zero");

	property p_tx_flag;
		@(posedge clk) disable iff (!rstn)
			(wr_fire && last_word && cur_tx_q) |-> word[TFRB_FLAG_TX_BIT];
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("transmitted record lacks transmit flag");

	property p_rx_flag;
		@(posedge clk) disable iff (!rstn)
			(wr_fire && last_word) |-> (word[TFRB_FLAG_RX_BIT] != word[TFRB_FLAG_TX_BIT]);
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag does not match direction");

	property p_ep_no_tx;
		@(posedge clk) disable iff (!rstn)
			(ep_valid && ep_last) |-> !ep_data[TFRB_FLAG_TX_BIT];
	endproperty
	a_ep_no_tx: assert property (p_ep_no_tx) else $error("endpoint record shows transmit flag");

endmodule

// ==== include/tfrb_pkg.sv ====
// Constants shared by the timestamped frame record builder and its helpers.
// Assumes a free-running network time in nanoseconds and one system clock.
package tfrb_pkg;

	// Header words of one record, 32 bits each, in little-endian byte order.
	localparam logic [2:0] TFRB_HDR_WORDS = 3'h6;
	localparam logic [2:0] TFRB_W_LEN = 3'h0;
	localparam logic [2:0] TFRB_W_LTS_LO = 3'h1;
	localparam logic [2:0] TFRB_W_LTS_HI = 3'h2;
	localparam logic [2:0] TFRB_W_NTS_LO = 3'h3;
	localparam logic [2:0] TFRB_W_NTS_HI = 3'h4;
	localparam logic [2:0] TFRB_W_FLAGS = 3'h5;

	// Bytes of a record that are not frame data: 24 header bytes and the check sequence.
	localparam logic [15:0] TFRB_REC_OVERHEAD = 16'h001C;

	// Direction flags in the flags word.
	localparam int TFRB_FLAG_TX_BIT = 31;
	localparam int TFRB_FLAG_RX_BIT = 30;

	// Distance in nanoseconds from the point where the start-of-frame event is seen to the connector/PHY plane.
	localparam logic [63:0] TFRB_TX_LAT_NS = 64'h0000_0000_0000_0040;
	localparam logic [63:0] TFRB_RX_LAT_NS = 64'h0000_0000_0000_0060;
	// Distance in nanoseconds between this port's plane and the tap partner's plane.
	localparam logic [63:0] TFRB_PARTNER_PLANE_NS = 64'h0000_0000_0000_0080;

	// Output buffers.
	localparam int TFRB_FIFO_WIDTH = 33;
	localparam int TFRB_FIFO_DEPTH = 8;

	// Builder states.
	typedef enum logic [1:0] {
		TFRB_ST_IDLE = 2'b01,
		TFRB_ST_EMIT = 2'b10
	} tfrb_state_type;

endpackage

// ==== hdl/tfrb_fifo.sv ====
// Synchronous FIFO with a registered output stage.
// Assumes both sides run on the same clock as the record builder.
`timescale 1ns/1ps
module tfrb_fifo
	import tfrb_pkg::*;
#(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic [WIDTH-1:0] out_data_q;
	logic out_valid_q;
	logic wr_en;
	logic rd_en;

	assign in_ready = (count_q != FULL_COUNT);
	assign wr_en = in_valid && in_ready;
	// While a word waits in memory, the output stage reloads whenever it is empty or its word is taken.
	assign rd_en = (count_q != '0) && (!out_valid_q || out_ready);
	assign out_data = out_data_q;
	assign out_valid = out_valid_q;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (wr_en) begin
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			end
			if (rd_en) begin
				rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
			end
			if (wr_en && !rd_en) begin
				count_q <= CW'(count_q + 1'b1);
			end else if (rd_en && !wr_en) begin
				count_q <= CW'(count_q - 1'b1);
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (rd_en) begin
			out_valid_q <= 1'b1;
			out_data_q <= mem[rd_ptr_q];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	// A word offered while full must not move the write pointer.
	property p_full_blocks;
		@(posedge clk) disable iff (!rstn) (in_valid && count_q == FULL_COUNT) |=> $stable(wr_ptr_q);
	endproperty
	a_full_blocks: assert property (p_full_blocks) else $error("fifo accepts a word while full");

	property p_held_word;
		@(posedge clk) disable iff (!rstn) (out_valid_q && !out_ready) |=> (out_valid_q && $stable(out_data_q));
	endproperty
	a_held_word: assert property (p_held_word) else $error("fifo output changed while stalled");

endmodule

// ==== hdl/tfrb_tsadj.sv ====
// Moves a raw network time to the reference plane of the port or of the tap midpoint.
// Assumes the raw time is the network time at the cycle the start-of-frame event is seen.
`timescale 1ns/1ps
module tfrb_tsadj
	import tfrb_pkg::*;
(
	input wire logic [63:0] raw_ns,
	input wire logic is_tx,
	input wire logic tap_mode,
	output logic [63:0] ts_ns
);

	logic [63:0] plane_ns;
	logic [63:0] half_partner_ns;

	// A transmitted symbol reaches the connector later; a received one left it earlier.
	assign plane_ns = is_tx ? (raw_ns + TFRB_TX_LAT_NS) : (raw_ns - TFRB_RX_LAT_NS);
	assign half_partner_ns = TFRB_PARTNER_PLANE_NS >> 1;

	always_comb begin
		ts_ns = plane_ns;
		if (tap_mode) begin
			// Frames sent here came in at the partner, upstream; received frames go on downstream.
			if (is_tx) begin
				ts_ns = plane_ns - half_partner_ns;
			end else begin
				ts_ns = plane_ns + half_partner_ns;
			end
		end
	end

endmodule

// ==== dv/tfrb_host_model.sv ====
// Host read path model: takes one view's record stream, stalling at random or holding off entirely.
// Assumes the stream is sampled on the rising edge of clk.
`timescale 1ns/1ps
module tfrb_host_model #(
	parameter logic [15:0] SEED = 16'hACE1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hold,
	output logic ready
);
	logic [15:0] lfsr_q;

	// Ready moves only at the falling edge so that it is settled at the sampling edge.
	always @(negedge clk or negedge rstn) begin
		if (!rstn) begin
			lfsr_q <= SEED;
			ready <= 1'b0;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			ready <= !hold && (lfsr_q[1:0] != 2'h0);
		end
	end
endmodule

// ==== dv/tfrb_top_bench.sv ====
// Self-checking bench for the record builder: drives frame events and compares both record views.
// Assumes one 50 MHz clock; host read paths are modelled by tfrb_host_model.
`timescale 1ns/1ps
module tfrb_top_bench
	import tfrb_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic tap_mode = 1'b0;
	logic [63:0] net_time_ns = 64'h0;
	logic tx_sof = 1'b0;
	logic tx_eof = 1'b0;
	logic [15:0] tx_len = 16'h0;
	logic rx_sof = 1'b0;
	logic rx_eof = 1'b0;
	logic [15:0] rx_len = 16'h0;
	logic [31:0] mon_data;
	logic mon_last;
	logic mon_valid;
	logic mon_ready;
	logic [31:0] ep_data;
	logic ep_last;
	logic ep_valid;
	logic ep_ready;
	logic rec_drop;
	logic hold = 1'b0;
	logic [32:0] mon_q[$];
	logic [32:0] ep_q[$];
	int mismatches = 0;
	int total_checks = 0;
	int drops = 0;
	logic [63:0] rnd_q = 64'h0000_0000_0001_258D;

	always #10 clk = ~clk;

	tfrb_top u_dut (
		.clk(clk), .rstn(rstn), .tap_mode(tap_mode), .net_time_ns(net_time_ns),
		.tx_sof(tx_sof), .tx_eof(tx_eof), .tx_len(tx_len),
		.rx_sof(rx_sof), .rx_eof(rx_eof), .rx_len(rx_len),
		.mon_data(mon_data), .mon_last(mon_last), .mon_valid(mon_valid), .mon_ready(mon_ready),
		.ep_data(ep_data), .ep_last(ep_last), .ep_valid(ep_valid), .ep_ready(ep_ready),
		.rec_drop(rec_drop)
	);
	tfrb_host_model #(.SEED(16'hACE1)) u_mon_host (.clk(clk), .rstn(rstn), .hold(hold), .ready(mon_ready));
	tfrb_host_model #(.SEED(16'h5A3C)) u_ep_host (.clk(clk), .rstn(rstn), .hold(hold), .ready(ep_ready));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Summary: %0d checks, %0d mismatches", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	function automatic logic [63:0] xorshift(input logic [63:0] s);
		logic [63:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 7);
		return x ^ (x << 17);
	endfunction

	// Notes the six words of one record for the views that must carry it.
	task automatic push_rec(input logic is_tx, input logic [63:0] nt, input logic [15:0] len);
		logic [63:0] st;
		logic [31:0] w[6];
		st = is_tx ? nt + TFRB_TX_LAT_NS : nt - TFRB_RX_LAT_NS;
		if (tap_mode) begin
			st = is_tx ? st - (TFRB_PARTNER_PLANE_NS >> 1) : st + (TFRB_PARTNER_PLANE_NS >> 1);
		end
		w = '{{16'h0000, len + TFRB_REC_OVERHEAD}, 32'h0, 32'h0, st[31:0], st[63:32],
			is_tx ? 32'h8000_0000 : 32'h4000_0000};
		for (int i = 0; i < 6; i++) begin
			mon_q.push_back({i == 5, w[i]});
			if (!is_tx) begin
				ep_q.push_back({i == 5, w[i]});
			end
		end
	endtask

	// One frame per enabled direction; a zero length asks for a random one.
	task automatic send(input logic do_tx, input logic do_rx, input int gap, input logic keep, input logic [15:0] fix);
		logic [63:0] nt;
		logic [15:0] len;
		rnd_q = xorshift(rnd_q);
		nt = rnd_q;
		len = (fix != 16'h0) ? fix : 16'h002E + {5'h00, rnd_q[10:0]};
		@(negedge clk);
		net_time_ns = nt;
		tx_sof = do_tx;
		rx_sof = do_rx;
		@(negedge clk);
		tx_sof = 1'b0;
		rx_sof = 1'b0;
		net_time_ns = ~nt;
		repeat (gap) @(negedge clk);
		tx_eof = do_tx;
		rx_eof = do_rx;
		tx_len = len;
		rx_len = len;
		if (keep && do_rx) begin
			push_rec(1'b0, nt, len);
		end
		if (keep && do_tx) begin
			push_rec(1'b1, nt, len);
		end
		@(negedge clk);
		tx_eof = 1'b0;
		rx_eof = 1'b0;
		tx_len = ~len;
		rx_len = len ^ 16'h5555;
	endtask

	task automatic drain();
		int n;
		n = 0;
		while ((mon_q.size() != 0 || ep_q.size() != 0) && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("MISMATCH at %0t: records did not arrive", $time);
			print_verdict();
		end
		repeat (4) @(negedge clk);
	endtask

	always @(posedge clk) begin
		if (rstn && rec_drop === 1'b1) begin
			drops++;
		end
		if (rstn && mon_valid === 1'b1 && mon_ready === 1'b1) begin
			check({mon_last, mon_data}, mon_q.size() ? mon_q.pop_front() : ~{mon_last, mon_data}, "monitor word");
		end
		if (rstn && ep_valid === 1'b1 && ep_ready === 1'b1) begin
			check({ep_last, ep_data}, ep_q.size() ? ep_q.pop_front() : ~{ep_last, ep_data}, "endpoint word");
		end
	end

	initial begin
		repeat (5) @(negedge clk);
		check({30'h0, mon_valid, ep_valid, rec_drop}, 33'h0, "outputs in reset");
		rstn = 1'b1;
		for (int m = 0; m < 2; m++) begin
			tap_mode = m[0];
			for (int k = 0; k < 6; k++) begin
				send(k[0], k[1] | !k[0], k, 1'b1, 16'h0);
				drain();
			end
		end
		send(1'b1, 1'b1, 3, 1'b1, 16'hFFE3);
		drain();
		// Both views stalled: three records fit in fifos, builder and slot, the fourth is refused.
		tap_mode = 1'b0;
		hold = 1'b1;
		for (int f = 0; f < 4; f++) begin
			send(1'b0, 1'b1, 8, f < 3, 16'h0);
		end
		repeat (10) @(negedge clk);
		hold = 1'b0;
		drain();
		check(33'(drops), 33'h1, "dropped records");
		print_verdict();
	end
endmodule
